// File: pkg/ebh_regs.vh
// constants for the external bus hold and ready controller
`ifndef EBH_REGS_VH
`define EBH_REGS_VH

// register byte addresses
`define EBH_ADR_CTRL        4'h0
`define EBH_ADR_STATUS      4'h4

// control register fields
`define EBH_CTRL_MUX        0
`define EBH_CTRL_TRI_WS     1
`define EBH_CTRL_RWDLY      2
`define EBH_CTRL_RDY_EN     3
`define EBH_CTRL_HOLD_EN    4
`define EBH_CTRL_WS_LO      8
`define EBH_CTRL_WS_HI      11
`define EBH_CTRL_RESET      12'h0018
`define EBH_CTRL_WMASK      12'h0f1f

// status register fields
`define EBH_STAT_STATE_HI   3
`define EBH_STAT_HOLD_ACK   4
`define EBH_STAT_BUS_REQ    5
`define EBH_STAT_BUSY       6
`define EBH_STAT_RELEASED   7

// timing: clock output half period in system clocks, and the
// number of clock output cycles after the grant before bus request may rise
`define EBH_HALF_CLOCK_PERIOD  2
`define EBH_BUS_REQ_MIN_CYCLES 2

// bus sequencer states
`define EBH_ST_IDLE    4'h0
`define EBH_ST_ADDR    4'h1
`define EBH_ST_RWDLY   4'h2
`define EBH_ST_WS      4'h3
`define EBH_ST_CMD     4'h4
`define EBH_ST_MUXWS   4'h5
`define EBH_ST_TTC     4'h6
`define EBH_ST_REL     4'h7
`define EBH_ST_HELD    4'h8
`define EBH_ST_REGAIN  4'h9
`define EBH_ST_DRIVE   4'ha

`endif

// File: verilog/ebh_bus_ctrl.v
// external bus cycle controller with ready wait states and hold arbitration
//
// Design decisions made here: the address map and register access over Wishbone.
`timescale 1ns/100ps
`default_nettype none
`include "ebh_regs.vh"

module ebh_bus_ctrl #(
   parameter HALF_DIV  = `EBH_HALF_CLOCK_PERIOD,
   parameter REQ_MIN   = `EBH_BUS_REQ_MIN_CYCLES,
   parameter CS_W      = 4
) (
   input  wire            clk_sys,
   input  wire            rst_b,
   // classic wishbone slave
   input  wire            wb_cyc_i,
   input  wire            wb_stb_i,
   input  wire            wb_we_i,
   input  wire [3:0]      wb_adr_i,
   input  wire [3:0]      wb_sel_i,
   input  wire [31:0]     wb_dat_i,
   output reg  [31:0]     wb_dat_o,
   output wire            wb_ack_o,
   // core side request port
   input  wire            core_req,
   input  wire            core_we,
   input  wire [CS_W-1:0] core_cs_sel,
   output wire            core_done,
   // external bus pins
   output wire            clock_output,
   input  wire            ready_b,
   input  wire            hold_req_b,
   output wire            hold_ack_out,
   output wire            bus_request_out,
   output wire            ale_out,
   output wire            rd_b_out,
   output wire            wr_b_out,
   output wire            bus_oe,
   output wire [CS_W-1:0] chip_select_outputs_b,
   output wire [CS_W-1:0] chip_select_outputs_oe
);

   // clock output divider
   reg  [7:0]       div_cnt_ff;
   reg  [7:0]       nxt_div_cnt;
   reg              clk_out_ff;
   wire             div_wrap;
   wire             tick;

   // configuration and wishbone
   reg  [11:0]      ctrl_ff;
   reg              ack_ff;
   wire             wb_hit;
   wire [31:0]      status_word;
   wire [11:0]      wr_mask;

   // sequencer
   reg  [3:0]       state_ff;
   reg  [3:0]       nxt_state;
   reg  [3:0]       wait_cnt_ff;
   reg  [3:0]       nxt_wait_cnt;
   reg  [7:0]       req_cnt_ff;
   reg  [7:0]       nxt_req_cnt;
   reg              we_ff;
   reg  [CS_W-1:0]  cs_ff;
   reg              ale_ff;
   reg              rd_b_ff;
   reg              wr_b_ff;
   reg              oe_ff;
   reg              ack_out_ff;
   reg              bus_req_ff;
   reg              done_ff;
   reg              nxt_ale;
   reg              nxt_rd_b;
   reg              nxt_wr_b;
   reg              nxt_oe;
   reg              nxt_ack_out;
   reg              nxt_bus_req;
   reg              nxt_done;

   wire             cfg_mux;
   wire             cfg_tri_ws;
   wire             cfg_rwdly;
   wire             cfg_rdy_en;
   wire             cfg_hold_en;
   wire [3:0]       cfg_ws_cnt;
   wire             hold_req;

   // state after the data phase ends
   function [3:0] after_cmd;
      input mux;
      input tri_ws;
      begin
         if (mux) begin
            after_cmd = `EBH_ST_MUXWS;
         end else if (tri_ws) begin
            after_cmd = `EBH_ST_TTC;
         end else begin
            after_cmd = `EBH_ST_IDLE;
         end
      end
   endfunction

   assign cfg_mux     = ctrl_ff[`EBH_CTRL_MUX];
   assign cfg_tri_ws  = ctrl_ff[`EBH_CTRL_TRI_WS];
   assign cfg_rwdly   = ctrl_ff[`EBH_CTRL_RWDLY];
   assign cfg_rdy_en  = ctrl_ff[`EBH_CTRL_RDY_EN];
   assign cfg_hold_en = ctrl_ff[`EBH_CTRL_HOLD_EN];
   assign cfg_ws_cnt  = ctrl_ff[`EBH_CTRL_WS_HI:`EBH_CTRL_WS_LO];
   assign hold_req    = ~hold_req_b & cfg_hold_en;

   // clock output: tick marks each rising edge of the output clock
   assign div_wrap = (div_cnt_ff == HALF_DIV[7:0] - 8'h01);
   assign tick     = div_wrap & ~clk_out_ff;

   always @* begin
      if (div_wrap) begin
         nxt_div_cnt = 8'h00;
      end else begin
         nxt_div_cnt = div_cnt_ff + 8'h01;
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         div_cnt_ff <= 8'h00;
         clk_out_ff <= 1'b0;
      end else begin
         div_cnt_ff <= nxt_div_cnt;
         if (div_wrap) begin
            clk_out_ff <= ~clk_out_ff;
         end
      end
   end

   assign clock_output = clk_out_ff;

   // wishbone slave, ack one cycle after the request, dropped next cycle
   assign wb_hit   = wb_cyc_i & wb_stb_i & ~ack_ff;
   assign wb_ack_o = ack_ff;
   assign wr_mask  = `EBH_CTRL_WMASK;

   assign status_word = {24'h0000_00, ~oe_ff, (state_ff != `EBH_ST_IDLE), bus_req_ff, ack_out_ff, state_ff};

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         ack_ff   <= 1'b0;
         ctrl_ff  <= `EBH_CTRL_RESET;
         wb_dat_o <= 32'h0000_0000;
      end else begin
         ack_ff <= wb_hit;
         if (wb_hit && wb_we_i && wb_adr_i == `EBH_ADR_CTRL) begin
            if (wb_sel_i[0]) begin
               ctrl_ff[7:0] <= wb_dat_i[7:0] & wr_mask[7:0];
            end
            if (wb_sel_i[1]) begin
               ctrl_ff[11:8] <= wb_dat_i[11:8];
            end
         end
         if (wb_hit && !wb_we_i) begin
            case (wb_adr_i)
               `EBH_ADR_CTRL: begin
                  wb_dat_o <= {20'h0_0000, ctrl_ff};
               end
               `EBH_ADR_STATUS: begin
                  wb_dat_o <= status_word;
               end
               default: begin
                  wb_dat_o <= 32'h0000_0000;
               end
            endcase
         end
      end
   end

   // bus sequencer, advances once per output clock cycle
   always @* begin
      nxt_state    = state_ff;
      nxt_wait_cnt = wait_cnt_ff;
      nxt_req_cnt  = req_cnt_ff;
      nxt_ale      = ale_ff;
      nxt_rd_b     = rd_b_ff;
      nxt_wr_b     = wr_b_ff;
      nxt_oe       = oe_ff;
      nxt_ack_out  = ack_out_ff;
      nxt_bus_req  = bus_req_ff;
      nxt_done     = 1'b0;
      if (tick) begin
         case (state_ff)
            `EBH_ST_IDLE: begin
               if (hold_req) begin
                  // nothing running here, so the bus may be released
                  nxt_state = `EBH_ST_REL;
                  nxt_oe    = 1'b0;
               end else if (core_req) begin
                  nxt_state = `EBH_ST_ADDR;
                  nxt_ale   = 1'b1;
               end
            end
            `EBH_ST_ADDR: begin
               nxt_ale      = 1'b0;
               nxt_wait_cnt = cfg_ws_cnt;
               if (cfg_rwdly) begin
                  nxt_state = `EBH_ST_RWDLY;
               end else if (cfg_ws_cnt != 4'h0) begin
                  nxt_state = `EBH_ST_WS;
                  nxt_rd_b  = we_ff;
                  nxt_wr_b  = ~we_ff;
               end else begin
                  nxt_state = `EBH_ST_CMD;
                  nxt_rd_b  = we_ff;
                  nxt_wr_b  = ~we_ff;
               end
            end
            `EBH_ST_RWDLY: begin
               // command edge delayed by one cycle
               nxt_rd_b = we_ff;
               nxt_wr_b = ~we_ff;
               if (cfg_ws_cnt != 4'h0) begin
                  nxt_state = `EBH_ST_WS;
               end else begin
                  nxt_state = `EBH_ST_CMD;
               end
            end
            `EBH_ST_WS: begin
               nxt_wait_cnt = wait_cnt_ff - 4'h1;
               if (wait_cnt_ff == 4'h1) begin
                  nxt_state = `EBH_ST_CMD;
               end
            end
            `EBH_ST_CMD: begin
               // ready sampled once per output clock rising edge only
               if (cfg_rdy_en && ready_b) begin
                  nxt_state = `EBH_ST_CMD;
               end else begin
                  nxt_state = after_cmd(cfg_mux, cfg_tri_ws);
                  nxt_rd_b  = 1'b1;
                  nxt_wr_b  = 1'b1;
                  nxt_done  = 1'b1;
               end
            end
            `EBH_ST_MUXWS: begin
               if (cfg_tri_ws) begin
                  nxt_state = `EBH_ST_TTC;
               end else begin
                  nxt_state = `EBH_ST_IDLE;
               end
            end
            `EBH_ST_TTC: begin
               nxt_state = `EBH_ST_IDLE;
            end
            `EBH_ST_REL: begin
               // drivers already off, now grant
               nxt_ack_out  = 1'b1;
               nxt_req_cnt  = 8'h00;
               nxt_state    = `EBH_ST_HELD;
            end
            `EBH_ST_HELD: begin
               if (!hold_req) begin
                  // regain on hold going inactive, requested or not
                  nxt_state   = `EBH_ST_REGAIN;
                  nxt_ack_out = 1'b0;
                  nxt_bus_req = 1'b0;
               end else begin
                  if (req_cnt_ff != REQ_MIN[7:0]) begin
                     nxt_req_cnt = req_cnt_ff + 8'h01;
                  end
                  nxt_bus_req = core_req & (req_cnt_ff == REQ_MIN[7:0]);
               end
            end
            `EBH_ST_REGAIN: begin
               nxt_oe    = 1'b1;
               nxt_state = `EBH_ST_DRIVE;
            end
            `EBH_ST_DRIVE: begin
               nxt_state = `EBH_ST_IDLE;
            end
            default: begin
               nxt_state = `EBH_ST_IDLE;
            end
         endcase
      end
   end

   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         state_ff    <= `EBH_ST_IDLE;
         wait_cnt_ff <= 4'h0;
         req_cnt_ff  <= 8'h00;
         we_ff       <= 1'b0;
         cs_ff       <= {CS_W{1'b0}};
         ale_ff      <= 1'b0;
         rd_b_ff     <= 1'b1;
         wr_b_ff     <= 1'b1;
         oe_ff       <= 1'b1;
         ack_out_ff  <= 1'b0;
         bus_req_ff  <= 1'b0;
         done_ff     <= 1'b0;
      end else begin
         state_ff    <= nxt_state;
         wait_cnt_ff <= nxt_wait_cnt;
         req_cnt_ff  <= nxt_req_cnt;
         ale_ff      <= nxt_ale;
         rd_b_ff     <= nxt_rd_b;
         wr_b_ff     <= nxt_wr_b;
         oe_ff       <= nxt_oe;
         ack_out_ff  <= nxt_ack_out;
         bus_req_ff  <= nxt_bus_req;
         done_ff     <= nxt_done;
         if (tick && state_ff == `EBH_ST_IDLE && !hold_req && core_req) begin
            we_ff <= core_we;
            cs_ff <= core_cs_sel;
         end else if (nxt_done) begin
            cs_ff <= {CS_W{1'b0}};
         end
      end
   end

   assign core_done              = done_ff;
   assign hold_ack_out           = ack_out_ff;
   assign bus_request_out        = bus_req_ff;
   assign ale_out                = ale_ff;
   assign rd_b_out               = rd_b_ff;
   assign wr_b_out               = wr_b_ff;
   assign bus_oe                 = oe_ff;
   assign chip_select_outputs_b  = ~cs_ff;
   assign chip_select_outputs_oe = {CS_W{oe_ff}};

endmodule // ebh_bus_ctrl
`default_nettype wire

// File: verif/ebh_bus_ctrl_checker.sv
// concurrent checks on the external bus controller pins
`timescale 1ns/100ps
`default_nettype none
module ebh_bus_ctrl_checker #(
   parameter CS_W = 4
) (
   input wire logic            clk_sys,
   input wire logic            rst_b,
   input wire logic            ready_b,
   input wire logic            hold_req_b,
   input wire logic            hold_ack_out,
   input wire logic            bus_request_out,
   input wire logic            ale_out,
   input wire logic            rd_b_out,
   input wire logic            wr_b_out,
   input wire logic            bus_oe,
   input wire logic            core_done,
   input wire logic [CS_W-1:0] chip_select_outputs_oe
);
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   wire logic stb_hi;
   logic [7:0] rdy_lo_cnt;
   assign stb_hi = rd_b_out & wr_b_out;
   // ready may be low through the programmed waits, so bound the whole span
   always @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         rdy_lo_cnt <= 8'h00;
      end else if (!ready_b && !stb_hi) begin
         rdy_lo_cnt <= rdy_lo_cnt + 8'h01;
      end else begin
         rdy_lo_cnt <= 8'h00;
      end
   end
   chk_ready_holds: assert property ($rose(stb_hi) |-> !ready_b) else $error("strobe ended without ready");
   chk_ready_ends: assert property (rdy_lo_cnt < 8'h48) else $error("ready low ignored");
   chk_done_idle: assert property (core_done |-> stb_hi) else $error("done with strobe low");
   // address phase is one output clock of four system clocks
   chk_ale_pulse: assert property ($rose(ale_out) |-> (ale_out && stb_hi) [*4] ##1 !ale_out)
      else $error("address phase wrong");
   chk_hold_finish: assert property ($rose(hold_ack_out) |-> stb_hi && !ale_out) else $error("grant mid cycle");
   chk_ack_after: assert property ($rose(hold_ack_out) |-> !bus_oe && !$past(bus_oe, 2))
      else $error("ack before release");
   chk_cs_float: assert property (hold_ack_out |-> chip_select_outputs_oe == '0) else $error("cs driven");
   chk_req_early: assert property ($rose(hold_ack_out) |-> !bus_request_out [*8]) else $error("request early");
   chk_req_held: assert property (bus_request_out |-> hold_ack_out) else $error("request outside hold");
   chk_regain_go: assert property (hold_ack_out && $rose(hold_req_b) |-> ##[1:16] !hold_ack_out)
      else $error("no regain");
   chk_redrive_order: assert property ($rose(bus_oe) |-> !hold_ack_out) else $error("drive under ack");
endmodule // ebh_bus_ctrl_checker
bind ebh_bus_ctrl ebh_bus_ctrl_checker #(.CS_W(CS_W)) ebh_bus_ctrl_checker_inst (.clk_sys(clk_sys), .rst_b(rst_b),
   .ready_b(ready_b), .hold_req_b(hold_req_b), .hold_ack_out(hold_ack_out), .bus_request_out(bus_request_out),
   .ale_out(ale_out), .rd_b_out(rd_b_out), .wr_b_out(wr_b_out), .bus_oe(bus_oe), .core_done(core_done),
   .chip_select_outputs_oe(chip_select_outputs_oe));
`default_nettype wire

// File: verif/ebh_far_model.sv
// ready peripheral and hold master on the external bus
`timescale 1ns/100ps
`default_nettype none
module ebh_far_model (
   input wire logic       clk_sys,
   input wire logic       rst_b,
   input wire logic       clock_output,
   input wire logic       rd_b_out,
   input wire logic       wr_b_out,
   input wire logic [3:0] rdy_wait,
   input wire logic       hold_want,
   output logic           ready_b,
   output logic           hold_req_b
);
   logic       co_q;
   logic [3:0] cnt;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         co_q <= 1'b0;
         cnt <= 4'h0;
         ready_b <= 1'b1;
         hold_req_b <= 1'b1;
      end else begin
         co_q <= clock_output;
         hold_req_b <= ~hold_want;
         if (rd_b_out & wr_b_out) begin
            cnt <= 4'h0;
            ready_b <= 1'b1;
         end else if (co_q & ~clock_output) begin
            cnt <= cnt + 4'h1;
            if (cnt >= rdy_wait) ready_b <= 1'b0;
         end
      end
   end
endmodule // ebh_far_model
`default_nettype wire

// File: verif/tb.sv
// self-checking bench for the external bus controller
`timescale 1ns/100ps
`default_nettype none
`define CHK(n, e, a) begin check_count++; if ((a) !== (e)) begin mismatches++; \
   $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module tb;
   logic        clk_sys = 1'b0;
   logic        rst_b = 1'b0;
   logic        wb_cyc_i = 1'b0;
   logic        wb_stb_i = 1'b0;
   logic        wb_we_i = 1'b0;
   logic [3:0]  wb_adr_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000;
   logic [31:0] wb_dat_o;
   logic        wb_ack_o, core_done, clock_output, ready_b, hold_req_b, hold_ack_out;
   logic        bus_request_out, ale_out, rd_b_out, wr_b_out, bus_oe;
   logic        core_req = 1'b0;
   logic        core_we = 1'b1;
   logic        hold_want = 1'b0;
   logic [3:0]  rdy_wait = 4'h0;
   logic [3:0]  cs_b, cs_oe, cs_wire;
   logic        ale_q = 1'b0;
   logic        stb_q = 1'b1;
   int          cyc_n = 0;
   int          t_ale, t_sfall, t_srise, mismatches = 0, check_count = 0;
   assign cs_wire = (cs_b & cs_oe) | ~cs_oe;
   always #2 clk_sys = ~clk_sys;
   ebh_bus_ctrl ebh_bus_ctrl_inst (.clk_sys(clk_sys), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
      .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(4'hf), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
      .wb_ack_o(wb_ack_o), .core_req(core_req), .core_we(core_we), .core_cs_sel(4'h1), .core_done(core_done),
      .clock_output(clock_output), .ready_b(ready_b), .hold_req_b(hold_req_b), .hold_ack_out(hold_ack_out),
      .bus_request_out(bus_request_out), .ale_out(ale_out), .rd_b_out(rd_b_out), .wr_b_out(wr_b_out),
      .bus_oe(bus_oe), .chip_select_outputs_b(cs_b), .chip_select_outputs_oe(cs_oe));
   ebh_far_model ebh_far_model_inst (.clk_sys(clk_sys), .rst_b(rst_b), .clock_output(clock_output),
      .rd_b_out(rd_b_out), .wr_b_out(wr_b_out), .rdy_wait(rdy_wait), .hold_want(hold_want),
      .ready_b(ready_b), .hold_req_b(hold_req_b));
   always @(posedge clk_sys) begin
      cyc_n <= cyc_n + 1;
      ale_q <= ale_out;
      stb_q <= rd_b_out & wr_b_out;
      if (ale_out & ~ale_q) t_ale <= cyc_n;
      if (stb_q & ~(rd_b_out & wr_b_out)) t_sfall <= cyc_n;
      if (~stb_q & rd_b_out & wr_b_out) t_srise <= cyc_n;
   end
   task wb(input logic we, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
      int n;
      @(posedge clk_sys);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= a;
      wb_dat_i <= d;
      n = 0;
      do begin @(posedge clk_sys); n++; end while (wb_ack_o !== 1'b1 && n < 50);
      if (wb_ack_o !== 1'b1) mismatches++;
      q = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
   endtask
   task wait_on(input int s, input logic lv);
      int n;
      logic v;
      n = 0;
      do begin
         @(negedge clk_sys);
         n++;
         v = (s == 0) ? core_done : (s == 1) ? hold_ack_out : (s == 2) ? bus_request_out : ale_out;
      end while (v !== lv && n < 400);
      if (v !== lv) mismatches++;
   endtask
   task bus_cyc(input logic [11:0] ctl, input logic [3:0] k, output int len, output int cmd);
      logic [31:0] q;
      wb(1'b1, 4'h0, {20'h0_0000, ctl}, q);
      rdy_wait <= k;
      core_we <= ~core_we;
      @(posedge clk_sys) core_req <= 1'b1;
      wait_on(0, 1'b1);
      @(posedge clk_sys) core_req <= 1'b0;
      @(negedge clk_sys);
      len = t_srise - t_ale;
      cmd = t_sfall - t_ale;
   endtask
   task two_cyc(input logic [11:0] ctl, output int g);
      logic [31:0] q;
      int s1;
      wb(1'b1, 4'h0, {20'h0_0000, ctl}, q);
      rdy_wait <= 4'h0;
      @(posedge clk_sys) core_req <= 1'b1;
      wait_on(0, 1'b1);
      @(negedge clk_sys);
      s1 = t_srise;
      wait_on(0, 1'b1);
      @(posedge clk_sys) core_req <= 1'b0;
      @(negedge clk_sys);
      g = t_ale - s1;
   endtask
   task t_regs;
      logic [31:0] q;
      wb(1'b0, 4'h0, 32'h0000_0000, q);
      `CHK("ctrl_reset", 32'h0000_0018, q)
      wb(1'b1, 4'h0, 32'hffff_ffff, q);
      wb(1'b0, 4'h0, 32'h0000_0000, q);
      `CHK("ctrl_mask", 32'h0000_0f1f, q)
      wb(1'b0, 4'h8, 32'h0000_0000, q);
      `CHK("unmapped", 32'h0000_0000, q)
   endtask
   task t_cycles;
      int len, cmd;
      bus_cyc(12'h018, 4'h0, len, cmd);
      `CHK("len_plain", 8, len)
      `CHK("cmd_plain", 4, cmd)
      bus_cyc(12'h018, 4'h2, len, cmd);
      `CHK("len_ready", 16, len)
      bus_cyc(12'h01c, 4'h0, len, cmd);
      `CHK("cmd_rwdly", 8, cmd)
      bus_cyc(12'h318, 4'h0, len, cmd);
      `CHK("len_memory_cycle_time_waitstates", 20, len)
   endtask
   task t_gaps;
      int g0, g1, g2, g3;
      two_cyc(12'h018, g0);
      two_cyc(12'h019, g1);
      two_cyc(12'h01b, g2);
      two_cyc(12'h01a, g3);
      `CHK("gap_mux", 4, g1 - g0)
      `CHK("gap_mux_ttc", 8, g2 - g0)
      `CHK("gap_demux_ttc", 4, g3 - g0)
   endtask
   task t_hold_busy;
      int len, cmd;
      bus_cyc(12'h018, 4'h0, len, cmd);
      @(posedge clk_sys);
      rdy_wait <= 4'h3;
      core_req <= 1'b1;
      wait_on(3, 1'b1);
      @(posedge clk_sys) hold_want <= 1'b1;
      wait_on(1, 1'b1);
      `CHK("hold_ack", 1'b1, hold_ack_out)
      `CHK("cs_wire", 4'hf, cs_wire)
      `CHK("cs_oe", 4'h0, cs_oe)
      `CHK("bus_oe", 1'b0, bus_oe)
      wait_on(2, 1'b1);
      `CHK("bus_req", 1'b1, bus_request_out)
      @(posedge clk_sys) hold_want <= 1'b0;
      wait_on(1, 1'b0);
      `CHK("ack_drop", 1'b0, hold_ack_out)
      `CHK("bus_req_drop", 1'b0, bus_request_out)
      wait_on(0, 1'b1);
      `CHK("done_after", 1'b1, core_done)
      @(posedge clk_sys) core_req <= 1'b0;
   endtask
   task t_hold_idle;
      int len, cmd;
      @(posedge clk_sys) hold_want <= 1'b1;
      wait_on(1, 1'b1);
      repeat (40) @(negedge clk_sys);
      `CHK("bus_req_idle", 1'b0, bus_request_out)
      @(posedge clk_sys) hold_want <= 1'b0;
      wait_on(1, 1'b0);
      `CHK("ack_idle", 1'b0, hold_ack_out)
      bus_cyc(12'h018, 4'h0, len, cmd);
      `CHK("len_regain", 8, len)
   endtask
   task tally_and_finish;
      if (mismatches == 0 && check_count > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_b <= 1'b1;
      t_regs;
      t_cycles;
      t_gaps;
      t_hold_busy;
      t_hold_idle;
      tally_and_finish;
   end
   initial begin
      repeat (20000) @(posedge clk_sys);
      mismatches++;
      tally_and_finish;
   end
endmodule // tb
`default_nettype wire
